// >>> design/pmd_params.svh
// timing and layout constants for the page-mode dram host controller
`ifndef PMD_PARAMS_SVH
`define PMD_PARAMS_SVH

// ****************************************************************
// clock and conversion
// ****************************************************************
`define PMD_CLK_NS 8
// least times round up, longest times round down
`define PMD_CYC_MIN(ns) (((ns) + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_CYC_MAX(ns) ((ns) / `PMD_CLK_NS)

// ****************************************************************
// strobe timing, fastest grade, in ns
// ****************************************************************
`define PMD_T_RP_NS 30
`define PMD_T_RAS_NS 50
`define PMD_T_RAH_NS 8
`define PMD_T_RCD_NS 18
`define PMD_T_AA_NS 25
`define PMD_T_CWL_NS 13
`define PMD_T_CP_NS 8
`define PMD_T_OED_NS 13
`define PMD_T_RWD_NS 73
`define PMD_T_CWD_NS 36
`define PMD_T_CSR_NS 5
`define PMD_T_CHR_NS 10
`define PMD_T_RPS_NS 90
`define PMD_T_RASP_NS 100000
`define PMD_T_RASS_NS 100000
`define PMD_T_SRSETTLE_NS 10000
// one row every 64 ms / 4096 rows
`define PMD_T_REFROW_NS 15625

// ****************************************************************
// widths
// ****************************************************************
`define PMD_ADDR_W 12
`define PMD_DATA_W 16
`define PMD_RCNT_W 17

`endif

// >>> design/pmd_pkg.sv
// types shared by the page-mode dram host controller
package pmd_pkg;

  // ****************************************************************
  // pin bundle toward the memory, strobes active low
  // ****************************************************************
  typedef struct packed {
    logic ras_b;           // row strobe
    logic lo_cas_b;        // low_byte_column_strobe
    logic hi_cas_b;        // high_byte_column_strobe
    logic we_b;            // write select
    logic oe_b;            // output gate
    logic dq_oe;           // controller drives data lines
    logic [11:0] addr;     // multiplexed address
  } pmd_pins_t;

  // ****************************************************************
  // user request
  // ****************************************************************
  typedef struct packed {
    logic write;           // write (early-write)
    logic rmw;             // read then write same word
    logic [1:0] lanes;     // byte lanes for write, [1] high byte
    logic [11:0] row;
    logic [11:0] col;
    logic [15:0] wdata;
  } pmd_req_t;

  typedef enum logic [3:0] {
    S_IDLE, S_PRE, S_ROW, S_COL, S_CAS, S_TURN, S_RMW_WR, S_CHI,
    S_CBR_CAS, S_CBR_RAS, S_REF_HOLD, S_ROR, S_SR, S_SR_EXIT
  } pmd_state_t;

endpackage

// >>> design/pmd_refresh_tick.sv
// refresh pacing: one tick and a rolling row address per row interval
`include "pmd_params.svh"
module pmd_refresh_tick #(
  parameter int PERIOD_CYC = `PMD_CYC_MAX(`PMD_T_REFROW_NS),
  parameter int ROW_W = `PMD_ADDR_W
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick,
  output logic [ROW_W-1:0] row
);

  // ****************************************************************
  // interval counter, rounded down so rows are never late
  // ****************************************************************
  logic [15:0] cnt_q;         // cycles left in interval
  logic [15:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [ROW_W-1:0] row_q;    // next row for row-only refresh
  logic [ROW_W-1:0] row_d;

  // next values
  always_comb
  begin
    tick_d = 1'b0;
    row_d = row_q;
    cnt_d = cnt_q - 16'h0001;
    if (cnt_q == 16'h0000)
    begin
      cnt_d = 16'(PERIOD_CYC - 1);
      tick_d = 1'b1;
      row_d = row_q + 1'b1;
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
      row_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      row_q <= row_d;
    end
  end

  assign tick = tick_q;
  assign row = row_q;

endmodule

// >>> design/pmd_ctrl.sv
// page-mode dram host controller: cycles, page mode, refresh, self-refresh
// How it works
// - self-refresh holds row strobe 100 us
// - precharge 90 ns after self-refresh exit
// - column strobe 5 ns before row strobe
// - column strobe held 10 ns after row
// - lane strobes may come in either order
// - write select set up before strobe rises
// - early-write select timing met per lane
// - reads, writes, read-writes mix in page
// - row-only refresh keeps column strobes high
// - either lane starts strobe-first refresh
// - read-write select after 73 and 36 ns
// - wait 13 ns after gate before driving
// - row-to-column maxima only stretch access
// - row strobe page limit 100000 ns
`include "pmd_params.svh"
module pmd_ctrl #(
  parameter int PAGE_MAX_CYC = `PMD_CYC_MAX(`PMD_T_RASP_NS),
  parameter int SR_ENTRY_CYC = `PMD_CYC_MIN(`PMD_T_RASS_NS),
  parameter int SR_SETTLE_CYC = `PMD_CYC_MIN(`PMD_T_SRSETTLE_NS),
  parameter int REF_ROW_CYC = `PMD_CYC_MAX(`PMD_T_REFROW_NS)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire pmd_pkg::pmd_req_t req_in,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic refresh_by_row,
  input wire logic sr_req,
  output logic sr_active,
  output logic sr_unsettled,
  output pmd_pkg::pmd_pins_t pins,
  output logic [15:0] dq_o,
  input wire logic [15:0] dq_i
);

  // ****************************************************************
  // cycle counts
  // ****************************************************************
  localparam logic [7:0] RP = 8'(`PMD_CYC_MIN(`PMD_T_RP_NS));
  localparam logic [7:0] RAH = 8'(`PMD_CYC_MIN(`PMD_T_RAH_NS));
  localparam logic [7:0] RCD = 8'(`PMD_CYC_MIN(`PMD_T_RCD_NS));
  localparam logic [7:0] CAC = 8'(`PMD_CYC_MIN(`PMD_T_AA_NS));
  localparam logic [7:0] CWL = 8'(`PMD_CYC_MIN(`PMD_T_CWL_NS));
  localparam logic [7:0] CP = 8'(`PMD_CYC_MIN(`PMD_T_CP_NS));
  localparam logic [7:0] OED = 8'(`PMD_CYC_MIN(`PMD_T_OED_NS));
  localparam logic [7:0] CSR = 8'(`PMD_CYC_MIN(`PMD_T_CSR_NS));
  localparam logic [7:0] CHR = 8'(`PMD_CYC_MIN(`PMD_T_CHR_NS));
  localparam logic [7:0] RPS = 8'(`PMD_CYC_MIN(`PMD_T_RPS_NS));
  localparam logic [16:0] RASMIN = 17'(`PMD_CYC_MIN(`PMD_T_RAS_NS));
  localparam logic [16:0] RWD = 17'(`PMD_CYC_MIN(`PMD_T_RWD_NS));
  // margin keeps a last column cycle inside the page limit
  localparam logic [16:0] PAGE_LIM = 17'(PAGE_MAX_CYC - 16);
  localparam logic [16:0] SR_HOLD = 17'(SR_ENTRY_CYC);
  localparam logic [16:0] SR_SETTLE = 17'(SR_SETTLE_CYC);

  // ****************************************************************
  // state
  // ****************************************************************
  pmd_pkg::pmd_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;              // cycles left in state
  logic [16:0] ras_cnt_q, ras_cnt_d;     // cycles row strobe has been low
  pmd_pkg::pmd_req_t req_q, req_d;       // request being served
  logic pend_q, pend_d;                  // request waiting or in flight
  logic [11:0] open_row_q, open_row_d;   // row of the open page
  logic ref_pend_q, ref_pend_d;          // a row refresh is owed
  logic ready_q, ready_d;
  logic rsp_q, rsp_d;
  logic [15:0] rdata_q, rdata_d;
  logic sra_q, sra_d;
  logic sru_q, sru_d;
  pmd_pkg::pmd_pins_t pins_q, pins_d;
  logic [15:0] dqo_q, dqo_d;
  logic ref_tick;
  logic [11:0] ref_row;
  logic take;

  // refresh pacing, one row per interval
  pmd_refresh_tick #(
    .PERIOD_CYC(REF_ROW_CYC),
    .ROW_W(12)
  ) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .tick(ref_tick),
    .row(ref_row)
  );

  // ****************************************************************
  // pin levels for each state
  // ****************************************************************
  function automatic pmd_pkg::pmd_pins_t pin_map(pmd_pkg::pmd_state_t s, pmd_pkg::pmd_req_t r,
                                                 logic [11:0] rrow);
    pmd_pkg::pmd_pins_t p;
    logic early;
    p = '{ras_b: 1'b1, lo_cas_b: 1'b1, hi_cas_b: 1'b1, we_b: 1'b1, oe_b: 1'b1, dq_oe: 1'b0,
          addr: 12'h000};
    early = r.write && !r.rmw;
    case (s)
      pmd_pkg::S_ROW:
      begin
        p.ras_b = 1'b0;
        p.addr = r.row;
      end
      pmd_pkg::S_COL:
      begin
        // early write: select and data lead the strobe
        p.ras_b = 1'b0;
        p.addr = r.col;
        p.we_b = !early;
        p.dq_oe = early;
      end
      pmd_pkg::S_CAS:
      begin
        // both lanes fall together, one column latch; an early write drops only its chosen lanes
        p.ras_b = 1'b0;
        p.addr = r.col;
        p.lo_cas_b = early ? !r.lanes[0] : 1'b0;
        p.hi_cas_b = early ? !r.lanes[1] : 1'b0;
        p.we_b = !early;
        p.dq_oe = early;
        p.oe_b = early;
      end
      pmd_pkg::S_TURN:
      begin
        // gate released, data lines left alone
        p.ras_b = 1'b0;
        p.addr = r.col;
        p.lo_cas_b = 1'b0;
        p.hi_cas_b = 1'b0;
      end
      pmd_pkg::S_RMW_WR:
      begin
        p.ras_b = 1'b0;
        p.addr = r.col;
        p.lo_cas_b = 1'b0;
        p.hi_cas_b = 1'b0;
        p.we_b = 1'b0;
        p.dq_oe = 1'b1;
      end
      pmd_pkg::S_CHI, pmd_pkg::S_REF_HOLD:
        p.ras_b = 1'b0;
      pmd_pkg::S_CBR_CAS:
      begin
        // both lanes lead the row strobe
        p.lo_cas_b = 1'b0;
        p.hi_cas_b = 1'b0;
      end
      pmd_pkg::S_CBR_RAS, pmd_pkg::S_SR:
      begin
        p.ras_b = 1'b0;
        p.lo_cas_b = 1'b0;
        p.hi_cas_b = 1'b0;
      end
      pmd_pkg::S_ROR:
      begin
        // row-only refresh, column strobes stay high
        p.ras_b = 1'b0;
        p.addr = rrow;
      end
      default:
        p.ras_b = 1'b1;
    endcase
    return p;
  endfunction

  // ****************************************************************
  // sequencer next values
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d = (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
    req_d = req_q;
    pend_d = pend_q;
    open_row_d = open_row_q;
    ref_pend_d = ref_pend_q | ref_tick;   // new tick beats the clear
    rsp_d = 1'b0;
    rdata_d = rdata_q;
    take = req_valid && ready_q;
    if (take)
    begin
      req_d = req_in;
      pend_d = 1'b1;
    end
    case (state_q)
      pmd_pkg::S_IDLE:
      begin
        // self-refresh and owed refresh go ahead of user work
        if (sr_req || ref_pend_q)
        begin
          ref_pend_d = ref_tick;
          state_d = (refresh_by_row && !sr_req) ? pmd_pkg::S_ROR : pmd_pkg::S_CBR_CAS;
          cnt_d = CSR - 8'h01;
        end
        else if (pend_q)
        begin
          state_d = pmd_pkg::S_ROW;
          open_row_d = req_q.row;
          cnt_d = RAH - 8'h01;
        end
      end
      pmd_pkg::S_ROW:
        if (cnt_q == 8'h00)
        begin
          state_d = pmd_pkg::S_COL;
          // least delay only; a later strobe just stretches access
          cnt_d = RCD - RAH - 8'h01;
        end
      pmd_pkg::S_COL:
        if (cnt_q == 8'h00)
        begin
          state_d = pmd_pkg::S_CAS;
          cnt_d = (req_q.write && !req_q.rmw) ? CWL - 8'h01 : CAC - 8'h01;
        end
      pmd_pkg::S_CAS:
        if (cnt_q == 8'h00)
        begin
          if (!req_q.write || req_q.rmw)
          begin
            // strobe held past the slowest access path
            rdata_d = dq_i;
            rsp_d = 1'b1;
          end
          if (req_q.rmw)
          begin
            state_d = pmd_pkg::S_TURN;
            cnt_d = OED - 8'h01;
          end
          else
          begin
            state_d = pmd_pkg::S_CHI;
            pend_d = 1'b0;
            cnt_d = CP - 8'h01;
          end
        end
      pmd_pkg::S_TURN:
        // late write select only after row-strobe delay
        if (cnt_q == 8'h00 && ras_cnt_q >= RWD)
        begin
          state_d = pmd_pkg::S_RMW_WR;
          cnt_d = CWL - 8'h01;
        end
      pmd_pkg::S_RMW_WR:
        if (cnt_q == 8'h00)
        begin
          state_d = pmd_pkg::S_CHI;
          pend_d = 1'b0;
          cnt_d = CP - 8'h01;
        end
      pmd_pkg::S_CHI:
        if (cnt_q == 8'h00 && !take)
        begin
          // stay in page only for same row and inside the limit
          if (pend_q && req_q.row == open_row_q && ras_cnt_q < PAGE_LIM && !ref_pend_q)
          begin
            state_d = pmd_pkg::S_COL;
            cnt_d = 8'h00;
          end
          else if (ras_cnt_q >= RASMIN)
          begin
            state_d = pmd_pkg::S_PRE;
            cnt_d = RP - 8'h01;
          end
        end
      pmd_pkg::S_PRE, pmd_pkg::S_SR_EXIT:
        if (cnt_q == 8'h00)
          state_d = pmd_pkg::S_IDLE;
      pmd_pkg::S_CBR_CAS:
        if (cnt_q == 8'h00)
        begin
          state_d = pmd_pkg::S_CBR_RAS;
          cnt_d = CHR - 8'h01;
        end
      pmd_pkg::S_CBR_RAS:
        // column strobe held after row strobe falls
        if (cnt_q == 8'h00)
          state_d = sr_req ? pmd_pkg::S_SR : pmd_pkg::S_REF_HOLD;
      pmd_pkg::S_REF_HOLD, pmd_pkg::S_ROR:
        if (ras_cnt_q >= RASMIN)
        begin
          state_d = pmd_pkg::S_PRE;
          cnt_d = RP - 8'h01;
        end
      pmd_pkg::S_SR:
        // leave only after the full entry hold
        if (!sr_req && ras_cnt_q >= SR_HOLD)
        begin
          state_d = pmd_pkg::S_SR_EXIT;
          ref_pend_d = ref_tick;
          cnt_d = RPS - 8'h01;
        end
      default:
        state_d = pmd_pkg::S_IDLE;
    endcase
    pins_d = pin_map(state_d, req_d, ref_row);
    dqo_d = req_d.wdata;
    ras_cnt_d = pins_d.ras_b ? 17'h00000 : ((ras_cnt_q == 17'h1FFFF) ? ras_cnt_q : ras_cnt_q + 17'h00001);
    ready_d = (state_d == pmd_pkg::S_IDLE || state_d == pmd_pkg::S_CHI) && !pend_d && !sr_req && !ref_pend_d;
    // active once the entry hold is done; unsettled from the settle point until then
    sra_d = state_d == pmd_pkg::S_SR && ras_cnt_d >= SR_HOLD;
    sru_d = state_d == pmd_pkg::S_SR && ras_cnt_d >= SR_SETTLE && ras_cnt_d < SR_HOLD;
  end

  // ****************************************************************
  // registers only; pins idle high with data lines released
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= pmd_pkg::S_IDLE;
      cnt_q <= 8'h00;
      ras_cnt_q <= 17'h00000;
      req_q <= '0;
      pend_q <= 1'b0;
      open_row_q <= 12'h000;
      ref_pend_q <= 1'b0;
      ready_q <= 1'b0;
      rsp_q <= 1'b0;
      rdata_q <= 16'h0000;
      sra_q <= 1'b0;
      sru_q <= 1'b0;
      pins_q <= '{ras_b: 1'b1, lo_cas_b: 1'b1, hi_cas_b: 1'b1, we_b: 1'b1, oe_b: 1'b1, dq_oe: 1'b0,
                  addr: 12'h000};
      dqo_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ras_cnt_q <= ras_cnt_d;
      req_q <= req_d;
      pend_q <= pend_d;
      open_row_q <= open_row_d;
      ref_pend_q <= ref_pend_d;
      ready_q <= ready_d;
      rsp_q <= rsp_d;
      rdata_q <= rdata_d;
      sra_q <= sra_d;
      sru_q <= sru_d;
      pins_q <= pins_d;
      dqo_q <= dqo_d;
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_data = rdata_q;
  assign sr_active = sra_q;
  assign sr_unsettled = sru_q;
  assign pins = pins_q;
  assign dq_o = dqo_q;

  // ****************************************************************
  // checks on the driven pins
  // ****************************************************************
  logic [7:0] hi_cnt_q;   // cycles row strobe has been high, saturating
  logic after_sr_q;       // first row strobe since self-refresh exit
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hi_cnt_q <= 8'hFF;
      after_sr_q <= 1'b0;
    end
    else
    begin
      hi_cnt_q <= !pins_q.ras_b ? 8'h00 : ((hi_cnt_q == 8'hFF) ? hi_cnt_q : hi_cnt_q + 8'h01);
      after_sr_q <= (state_q == pmd_pkg::S_SR_EXIT) ? 1'b1 : (!pins_q.ras_b ? 1'b0 : after_sr_q);
    end
  end

  a_sr_entry_hold: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pins_q.ras_b) && $past(state_q) == pmd_pkg::S_SR |-> $past(ras_cnt_q) >= SR_HOLD)
    else $error("self-refresh left before the entry hold");
  a_sr_flag_window: assert property (@(posedge clk) disable iff (!rst_b)
    sr_unsettled |-> !sr_active && !pins_q.ras_b && ras_cnt_q >= SR_SETTLE)
    else $error("unsettled flag outside the entry window");
  a_sr_exit_pre: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(pins_q.ras_b) && after_sr_q |-> $past(hi_cnt_q) >= RPS - 8'h01)
    else $error("row strobe fell too soon after self-refresh");
  a_cbr_cas_lead: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(pins_q.ras_b) && !pins_q.lo_cas_b && state_q != pmd_pkg::S_ROW |->
      $past(!pins_q.lo_cas_b) && $past(!pins_q.hi_cas_b))
    else $error("column strobe did not lead the row strobe");
  a_cbr_cas_hold: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(pins_q.ras_b) && !pins_q.lo_cas_b |-> (!pins_q.lo_cas_b && !pins_q.hi_cas_b) [*2])
    else $error("column strobe released too soon after row strobe");
  a_ror_cas_high: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == pmd_pkg::S_ROR |-> pins_q.lo_cas_b && pins_q.hi_cas_b && !pins_q.ras_b)
    else $error("column strobe active in row-only refresh");
  a_early_we_hold: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(pins_q.lo_cas_b) && !pins_q.we_b && !pins_q.ras_b |-> $past(!pins_q.we_b) ##1 !pins_q.we_b)
    else $error("early write select not held around the strobe");
  a_rmw_we_late: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(pins_q.we_b) && !pins_q.lo_cas_b |-> ras_cnt_q >= RWD && $past(!pins_q.lo_cas_b, 5))
    else $error("read-write select too early");
  a_gate_to_data: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(pins_q.dq_oe) |-> $past(pins_q.oe_b, 1) && $past(pins_q.oe_b, 2))
    else $error("data driven too soon after output gate");
  a_read_sample: assert property (@(posedge clk) disable iff (!rst_b)
    rsp_valid |-> $past(!pins_q.oe_b, 1) && $past(!pins_q.lo_cas_b, 4))
    else $error("read sampled before access time");
  a_page_limit: assert property (@(posedge clk) disable iff (!rst_b)
    !pins_q.ras_b && state_q != pmd_pkg::S_SR |-> ras_cnt_q < 17'(PAGE_MAX_CYC))
    else $error("row strobe active past the page limit");
  a_lanes_together: assert property (@(posedge clk) disable iff (!rst_b)
    !pins_q.we_b || pins_q.lo_cas_b == pins_q.hi_cas_b)
    else $error("lanes split outside a byte write");

  c_read_done: cover property (@(posedge clk) disable iff (!rst_b) rsp_valid && !req_q.rmw);
  c_rmw_write: cover property (@(posedge clk) disable iff (!rst_b) state_q == pmd_pkg::S_RMW_WR);
  c_page_hit: cover property (@(posedge clk) disable iff (!rst_b)
    state_q == pmd_pkg::S_CHI ##1 state_q == pmd_pkg::S_COL);
  c_self_refresh: cover property (@(posedge clk) disable iff (!rst_b) $rose(sr_active));

endmodule

// >>> bench/pmd_dram_model.sv
// behavioural page-mode dram answering the host controller's pins
module pmd_dram_model (
  input wire logic clk,
  input wire pmd_pkg::pmd_pins_t pins,
  input wire logic [15:0] dq_o,
  output logic [15:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [int]; // sparse word store
  logic [11:0] row; // latched row
  logic [11:0] col; // latched column
  logic rp, lp, hp; // strobes at last sample
  int lc, hc; // cycles each lane strobe is low
  // ****************************************************************
  // strobe behaviour, sampled away from the launch edge
  // ****************************************************************
  initial
  begin
    {rp, lp, hp} = 3'b111;
    dq_i = 16'h0000;
    lc = 0;
    hc = 0;
  end
  // refresh of any kind leaves the store alone
  always @(negedge clk)
  begin : edge_proc
    logic [11:0] ca;
    logic [15:0] v;
    int k;
    if (rp && !pins.ras_b)
      row = pins.addr;
    ca = (lp && hp) ? pins.addr : col; // first lane down freezes it
    col = ca;
    k = {row, ca};
    v = mem.exists(k) ? mem[k] : 16'h0000;
    if (!pins.ras_b && !pins.we_b && pins.dq_oe)
    begin
      if (!pins.lo_cas_b)
        v[7:0] = dq_o[7:0]; // lane by its own strobe
      if (!pins.hi_cas_b)
        v[15:8] = dq_o[15:8];
      mem[k] = v;
    end
    lc = pins.lo_cas_b ? 0 : lc + 1;
    hc = pins.hi_cas_b ? 0 : hc + 1;
    // early or released lines toggle so stale data never looks valid
    dq_i[7:0] <= (!pins.oe_b && pins.we_b && lc > 2) ? v[7:0] : ~dq_i[7:0];
    dq_i[15:8] <= (!pins.oe_b && pins.we_b && hc > 2) ? v[15:8] : ~dq_i[15:8];
    {rp, lp, hp} = {pins.ras_b, pins.lo_cas_b, pins.hi_cas_b};
  end
endmodule

// >>> bench/testbench.sv
// self-checking bench for the page-mode dram host controller
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SRE = 40; // shortened entry hold
  localparam int SRS = 10; // shortened settle point
  localparam int RPS = (90 + 7) / 8; // exit precharge cycles
  logic clk, rst_b, req_valid, refresh_by_row, sr_req;
  logic req_ready, rsp_valid, sr_active, sr_unsettled;
  logic [15:0] rsp_data, dq_o, dq_i;
  pmd_pkg::pmd_req_t req_in;
  pmd_pkg::pmd_pins_t pins;
  int failures, cmp_count, lrun, hrun, n_ror, n_cbr;
  logic sr_seen, rp, lp, hp, cas_seen, cbr1, us_p;
  logic [15:0] shadow [int]; // expected memory
  pmd_ctrl #(.PAGE_MAX_CYC(60), .SR_ENTRY_CYC(SRE), .SR_SETTLE_CYC(SRS), .REF_ROW_CYC(200)) dut (
    .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_in(req_in), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .refresh_by_row(refresh_by_row), .sr_req(sr_req),
    .sr_active(sr_active), .sr_unsettled(sr_unsettled), .pins(pins), .dq_o(dq_o), .dq_i(dq_i));
  pmd_dram_model mem (.clk(clk), .pins(pins), .dq_o(dq_o), .dq_i(dq_i));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic report_and_stop;
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait: 0 answer, 1 ready, 2 self-refresh entered
  task automatic wait_sig(input int s);
    int n;
    n = 0;
    @(negedge clk);
    while ((s == 0 ? rsp_valid : s == 1 ? req_ready : sr_active) !== 1'b1)
    begin
      n++;
      if (n > 3000)
      begin
        failures++;
        $display("[ERR] t=%0t wait %0h timed out", $time, s);
        report_and_stop;
      end
      @(negedge clk);
    end
  endtask
  task automatic send(input pmd_pkg::pmd_req_t r);
    @(posedge clk);
    req_valid <= 1'b1;
    req_in <= r;
    wait_sig(1);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  function automatic logic [15:0] merge(input logic [15:0] o, d, input logic [1:0] ln);
    merge = {ln[1] ? d[15:8] : o[15:8], ln[0] ? d[7:0] : o[7:0]};
  endfunction
  task automatic rd(input logic [11:0] row, col);
    send('{write:1'b0, rmw:1'b0, lanes:2'b00, row:row, col:col, wdata:16'h0000});
    wait_sig(0);
    chk(rsp_data, shadow[{row, col}]);
  endtask
  // plain write of chosen lanes, or read-write returning the old word
  task automatic wr(input logic [11:0] row, col, input logic [1:0] ln, input logic [15:0] d, input logic rmw);
    int k;
    k = {row, col};
    if (!shadow.exists(k))
      shadow[k] = 16'h0000;
    send('{write:1'b1, rmw:rmw, lanes:ln, row:row, col:col, wdata:d});
    if (rmw)
    begin
      wait_sig(0);
      chk(rsp_data, shadow[k]);
    end
    shadow[k] = merge(shadow[k], d, rmw ? 2'b11 : ln);
  endtask
  // ****************************************************************
  // pin monitor
  // ****************************************************************
  always @(negedge clk)
  begin
    if (rst_b)
    begin
      if (cbr1)
        chk({15'h0000, pins.lo_cas_b & pins.hi_cas_b}, 16'h0000); // column held past row
      cbr1 = 1'b0;
      if (rp && !pins.ras_b)
      begin
        if (!(pins.lo_cas_b && pins.hi_cas_b))
        begin
          n_cbr++;
          cbr1 = 1'b1;
          chk({14'h0000, lp & !pins.lo_cas_b, hp & !pins.hi_cas_b}, 16'h0000); // column led
        end
        if (sr_seen)
          chk({15'h0000, hrun >= RPS}, 16'h0001); // exit precharge
        sr_seen = 1'b0;
        cas_seen = 1'b0;
      end
      if (!rp && pins.ras_b)
      begin
        if (!cas_seen && refresh_by_row)
          n_ror++;
        if (!sr_seen)
          chk({15'h0000, lrun <= 60}, 16'h0001); // page limit
      end
      if (sr_unsettled && !us_p)
        chk(16'(lrun + 1), 16'(SRS)); // current cycle counted
      if (sr_active && !sr_seen)
        chk(16'(lrun + 1), 16'(SRE)); // entry hold
      if (sr_active)
        sr_seen = 1'b1;
      cas_seen = cas_seen | !(pins.lo_cas_b && pins.hi_cas_b);
    end
    lrun = pins.ras_b ? 0 : lrun + 1;
    hrun = pins.ras_b ? hrun + 1 : 0;
    {rp, lp, hp, us_p} = {pins.ras_b, pins.lo_cas_b, pins.hi_cas_b, sr_unsettled};
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {rst_b, req_valid, refresh_by_row, sr_req, req_in} = '0;
    {failures, cmp_count, lrun, hrun, n_ror, n_cbr} = '0;
    {sr_seen, rp, lp, hp, cas_seen, cbr1, us_p} = 7'h38;
    void'($urandom(22021));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 64; i++)
      wr(12'(i / 16), 12'(i % 16), 2'b11, 16'($urandom), 1'b0);
    $display("test fill done");
    wr(12'h003, 12'h005, 2'b01, 16'hA55A, 1'b0); // low lane alone
    wr(12'h003, 12'h005, 2'b10, 16'h3CC3, 1'b0); // high lane alone
    rd(12'h003, 12'h005); // merged word in page
    wr(12'h003, 12'h005, 2'b11, 16'h0FF0, 1'b1); // read-write
    rd(12'h003, 12'h005);
    $display("test lanes done");
    for (int i = 0; i < 150; i++)
    begin
      if (i == 75)
      begin
        @(posedge clk);
        refresh_by_row <= 1'b1;
      end
      if ($urandom_range(0, 2) == 0)
        rd(12'($urandom_range(0, 3)), 12'($urandom_range(0, 15)));
      else
        wr(12'($urandom_range(0, 3)), 12'($urandom_range(0, 15)), 2'($urandom_range(1, 3)),
          16'($urandom), 1'($urandom_range(0, 1))); // mixed cycles
    end
    $display("test random mix done");
    @(posedge clk);
    sr_req <= 1'b1;
    wait_sig(2);
    repeat (20) @(posedge clk);
    sr_req <= 1'b0;
    rd(12'h003, 12'h005); // kept through self-refresh
    rd(12'h000, 12'h000);
    $display("test self-refresh done");
    chk({15'h0000, n_cbr > 0}, 16'h0001);
    chk({15'h0000, n_ror > 0}, 16'h0001);
    report_and_stop;
  end
endmodule
